// ==== bench/link_ctrl_chk_assertions.sv ====
// port checker for the link control block
// assumes one clock domain and binding onto radio_link_ctrl
`timescale 1ns/1ps
module link_ctrl_chk (
	input wire       clk,
	input wire       rst_n,
	input wire       low_power_en,
	input wire       sync_mode,
	input wire       low_batt,
	input wire       sleep_pin_oe,
	input wire       led_r,
	input wire       asleep_r,
	input wire       radio_ready_r,
	input wire       tx_out_valid,
	input wire       tx_out_ready,
	input wire       tx_out_last,
	input wire [7:0] tx_out_data,
	input wire       rx_out_valid,
	input wire       rx_out_ready,
	input wire [7:0] rx_out_data
);
	// ********
	// assertions
	// ********
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	pin_never_driven_a: assert property (!sleep_pin_oe)
		else $error("sleep pin driven");
	batt_led_on_a: assert property (low_batt |=> led_r)
		else $error("led dark on low battery");
	led_pulse_len_a: assert property ($rose(led_r) && !low_batt |-> led_r[*8])
		else $error("led pulse too short");
	asleep_no_radio_a: assert property (asleep_r |-> !radio_ready_r)
		else $error("radio ready while asleep");
	// wake takes the full startup time before the radio is usable
	wake_delay_a: assert property ($fell(asleep_r) && low_power_en |=>
		!radio_ready_r[*8] ##[38:46] radio_ready_r)
		else $error("wake delay wrong");
	sleep_needs_lp_a: assert property ($rose(asleep_r) |-> low_power_en && !sync_mode)
		else $error("sleep entered when not allowed");
	tx_hold_a: assert property (tx_out_valid && !tx_out_ready |=>
		tx_out_valid && $stable(tx_out_data) && $stable(tx_out_last))
		else $error("tx word lost during stall");
	rx_hold_a: assert property (rx_out_valid && !rx_out_ready |=>
		rx_out_valid && $stable(rx_out_data))
		else $error("rx word lost during stall");
	cover property ($rose(asleep_r));
	cover property (tx_out_valid && !tx_out_ready);
	cover property ($fell(asleep_r) ##[1:60] radio_ready_r);
endmodule // link_ctrl_chk

bind radio_link_ctrl link_ctrl_chk link_ctrl_chk_i (.clk(clk), .rst_n(rst_n),
	.low_power_en(low_power_en), .sync_mode(sync_mode), .low_batt(low_batt),
	.sleep_pin_oe(sleep_pin_oe), .led_r(led_r), .asleep_r(asleep_r),
	.radio_ready_r(radio_ready_r), .tx_out_valid(tx_out_valid),
	.tx_out_ready(tx_out_ready), .tx_out_last(tx_out_last), .tx_out_data(tx_out_data),
	.rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready), .rx_out_data(rx_out_data));

// ==== bench/radio_link_ctrl_tb.sv ====
// self-checking bench for radio_link_ctrl
// assumes shortened timing parameters and the peer model on the tx side
`timescale 1ns/1ps
module radio_link_ctrl_tb;
	reg               clk, rst_n, addr_mode, sync_mode, tdma_master, tdma_sync, wide_band;
	reg               low_power_en, low_batt, stall, sleep_pin_i, rx_out_ready;
	reg               tx_in_valid, tx_in_last, rx_in_valid, rx_in_last;
	reg        [7:0]  dest_addr, local_addr, slot_count, slot_index, rx_in_len, rx_in_rssi;
	reg        [7:0]  tx_in_data, rx_in_data;
	reg signed [7:0]  chan_rssi;
	reg        [6:0]  debounce_ms;
	reg        [1:0]  rssi_mode;
	reg        [2:0]  k;
	wire              tx_in_ready, tx_out_valid, tx_out_last, tx_out_ready, rx_in_ready;
	wire              rx_out_valid, rx_out_last, sleep_pin_o, sleep_pin_oe, led_r, asleep_r;
	wire              radio_ready_r, slot_mine_r, cycle_start_r, rssi_pwm_r;
	wire       [7:0]  tx_out_data, rx_out_data, cur_slot_r;
	integer           num_errors, checks, i, c, j;
	reg        [31:0] seed;
	reg        [8:0]  txq[$], rxq[$];

	radio_link_ctrl #(.SLOT_NB_CYC(200), .SLOT_WB_CYC(60), .WAKE_CYC(50), .MS_CYC(10),
		.LED_CYC(20), .SMP_CYC(30)) radio_link_ctrl_i (.clk(clk), .rst_n(rst_n),
		.addr_mode(addr_mode), .dest_addr(dest_addr), .local_addr(local_addr),
		.sync_mode(sync_mode), .tdma_master(tdma_master), .slot_count(slot_count),
		.slot_index(slot_index), .tdma_sync(tdma_sync), .wide_band(wide_band),
		.low_power_en(low_power_en), .debounce_ms(debounce_ms), .rssi_mode(rssi_mode),
		.chan_rssi(chan_rssi), .low_batt(low_batt), .tx_in_valid(tx_in_valid),
		.tx_in_data(tx_in_data), .tx_in_last(tx_in_last), .tx_in_ready(tx_in_ready),
		.tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data), .tx_out_last(tx_out_last),
		.tx_out_ready(tx_out_ready), .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data),
		.rx_in_last(rx_in_last), .rx_in_len(rx_in_len), .rx_in_rssi(rx_in_rssi),
		.rx_in_ready(rx_in_ready), .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data),
		.rx_out_last(rx_out_last), .rx_out_ready(rx_out_ready), .sleep_pin_i(sleep_pin_i),
		.sleep_pin_o(sleep_pin_o), .sleep_pin_oe(sleep_pin_oe), .led_r(led_r),
		.asleep_r(asleep_r), .radio_ready_r(radio_ready_r), .cur_slot_r(cur_slot_r),
		.slot_mine_r(slot_mine_r), .cycle_start_r(cycle_start_r), .rssi_pwm_r(rssi_pwm_r));
	radio_peer_model radio_peer_model_i (.clk(clk), .rst_n(rst_n), .stall(stall),
		.tx_out_ready(tx_out_ready));

	// ********
	// helpers
	// ********
	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp)
			begin
				num_errors = num_errors + 1;
				$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
			end
		end
	endtask
	task wt(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task end_sim;
		begin
			$display("errors %0d checks %0d", num_errors, checks);
			if (num_errors == 0 && checks > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task send_tx(input integer n);
		begin
			if (addr_mode)
			begin
				txq.push_back({1'b0, dest_addr});
				txq.push_back({1'b0, local_addr});
			end
			for (i = 0; i < n; i++)
			begin
				seed = xs(seed);
				tx_in_valid <= 1'b1;
				tx_in_data <= seed[7:0];
				tx_in_last <= (i == n - 1);
				txq.push_back({i == n - 1, seed[7:0]});
				@(posedge clk);
				while (!tx_in_ready) @(posedge clk);
			end
			tx_in_valid <= 1'b0;
			@(posedge clk);
		end
	endtask
	// the rssi byte is clamped to the reportable range
	task send_rx(input [7:0] d, input integer n, input [7:0] rs);
		reg ok;
		begin
			ok = !addr_mode || d == local_addr || d == 8'hFF;
			if (ok && rssi_mode == 2'h1)
			begin
				rxq.push_back({1'b0, n[7:0]});
				rxq.push_back({1'b0, $signed(rs) < -127 ? 8'h81 : $signed(rs) > -8 ? 8'hF8 : rs});
			end
			rx_in_len <= n;
			rx_in_rssi <= rs;
			for (i = addr_mode ? -2 : 0; i < n; i++)
			begin
				seed = xs(seed);
				rx_in_valid <= 1'b1;
				rx_in_data <= i == -2 ? d : seed[7:0];
				rx_in_last <= (i == n - 1);
				if (ok && i >= 0) rxq.push_back({i == n - 1, seed[7:0]});
				@(posedge clk);
				while (!rx_in_ready) @(posedge clk);
			end
			rx_in_valid <= 1'b0;
			@(posedge clk);
		end
	endtask

	// ********
	// clock, far side and result watcher
	// ********
	initial
	begin
		clk = 1'b0;
		forever #10 clk = !clk;
	end
	always @(posedge clk)
	begin
		k <= k + 3'h1;
		rx_out_ready <= (k != 3'h5);
		if (tx_out_valid && tx_out_ready)
			chk({tx_out_last, tx_out_data}, txq.size() ? txq.pop_front() : 9'h1FF);
		if (rx_out_valid && rx_out_ready)
			chk({rx_out_last, rx_out_data}, rxq.size() ? rxq.pop_front() : 9'h1FF);
	end
	initial
	begin
		#(20 * 40000);
		num_errors = num_errors + 1;
		end_sim;
	end

	// ********
	// scenarios
	// ********
	initial
	begin
		{rst_n, addr_mode, sync_mode, tdma_master, tdma_sync, wide_band, low_power_en} = 0;
		{low_batt, stall, tx_in_valid, tx_in_last, rx_in_valid, rx_in_last, rx_out_ready} = 0;
		{slot_count, slot_index, rx_in_len, rx_in_rssi, tx_in_data, rx_in_data, chan_rssi} = 0;
		{num_errors, checks, k, rssi_mode} = 0;
		dest_addr = 8'hFF;
		local_addr = 8'h07;
		debounce_ms = 7'h02;
		sleep_pin_i = 1'b1;
		seed = 32'h8A91;
		wt(10);
		rst_n <= 1'b1;
		addr_mode <= 1'b1;
		wt(2);
		send_tx(3);
		send_tx(1);
		for (c = 0; c < 30 && !led_r; c++) @(posedge clk);
		chk(led_r, 1);
		wt(20);
		dest_addr <= 8'h3C;
		wt(2);
		send_tx(1);
		addr_mode <= 1'b0;
		wt(2);
		send_tx(2);
		addr_mode <= 1'b1;
		for (j = 0; j < 3; j++)
		begin
			rssi_mode <= j;
			wt(2);
			send_rx(8'h07, 3, 8'h80);
			send_rx(8'h55, 2, 8'hF0);
			send_rx(8'hFF, 2, 8'hFE);
		end
		addr_mode <= 1'b0;
		rssi_mode <= 2'h1;
		wt(2);
		send_rx(8'h00, 4, 8'hC0);
		wt(60);
		chk(txq.size() + rxq.size(), 0);
		low_batt <= 1'b1;
		wt(3);
		chk(led_r, 1);
		low_batt <= 1'b0;
		wt(40);
		chk(led_r, 0);
		// pin edges ignored with low power off or in tdma mode
		for (j = 0; j < 2; j++)
		begin
			low_power_en <= j;
			sync_mode <= j;
			sleep_pin_i <= 1'b0;
			wt(40);
			chk(asleep_r, 0);
			chk({sleep_pin_oe, sleep_pin_o}, 2'h0);
			sleep_pin_i <= 1'b1;
			wt(40);
		end
		sync_mode <= 1'b0;
		sleep_pin_i <= 1'b0;
		wt(5);
		sleep_pin_i <= 1'b1;
		wt(40);
		chk(asleep_r, 0);
		stall <= 1'b1;
		fork send_tx(5); join_none
		wt(2);
		sleep_pin_i <= 1'b0;
		wt(40);
		chk(tx_in_ready, 0);
		chk(asleep_r, 0);
		stall <= 1'b0;
		for (c = 0; c < 200 && !asleep_r; c++) @(posedge clk);
		chk(asleep_r, 1);
		sleep_pin_i <= 1'b1;
		for (c = 0; c < 200 && !radio_ready_r; c++) @(posedge clk);
		sleep_pin_i <= 1'b0;
		debounce_ms <= 7'h03;
		for (c = 0; c < 200 && !asleep_r; c++) @(posedge clk);
		chk(c >= 30 && c < 40, 1);
		sleep_pin_i <= 1'b1;
		for (c = 0; c < 200 && !radio_ready_r; c++) @(posedge clk);
		chk(radio_ready_r, 1);
		chk(c >= 80 && c < 90, 1);
		low_power_en <= 1'b0;
		// master, slot count below the floor, then narrow band
		sync_mode <= 1'b1;
		tdma_master <= 1'b1;
		for (j = 0; j < 2; j++)
		begin
			wide_band <= !j;
			slot_count <= j ? 8'h0C : 8'h03;
			@(posedge clk);
			for (c = 0; c < 5000 && !cycle_start_r; c++) @(posedge clk);
			@(posedge clk);
			for (c = 1; c < 5000 && !cycle_start_r; c++) @(posedge clk);
			chk(c, j ? 2400 : 660);
		end
		tdma_master <= 1'b0;
		slot_index <= 8'h01;
		tdma_sync <= 1'b1;
		@(posedge clk);
		tdma_sync <= 1'b0;
		@(posedge clk);
		for (c = 0; c < 3000 && !slot_mine_r; c++) @(posedge clk);
		chk({slot_mine_r, cur_slot_r}, 9'h101);
		sync_mode <= 1'b0;
		// pwm duty in permille over one full period
		for (j = 0; j < 3; j++)
		begin
			rssi_mode <= j ? 2'h2 : 2'h0;
			chan_rssi <= j == 1 ? 8'h81 : 8'h00;
			wt(1100);
			c = 0;
			repeat (1000)
			begin
				@(posedge clk);
				c = c + rssi_pwm_r;
			end
			chk(c, j == 0 ? 0 : j == 1 ? 170 : 892);
		end
		end_sim;
	end
endmodule // radio_link_ctrl_tb

// ==== bench/radio_peer_model.sv ====
// radio engine model that takes the transmit stream
// assumes same clock; stall holds ready low to fill the buffers
`timescale 1ns/1ps
module radio_peer_model (
	input wire clk,
	input wire rst_n,
	input wire stall,
	output reg tx_out_ready
);
	reg [1:0] ph_r;
	// every fourth cycle busy, so back-pressure is always exercised
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ph_r <= 2'h0;
			tx_out_ready <= 1'b0;
		end
		else
		begin
			ph_r <= ph_r + 2'h1;
			tx_out_ready <= !stall && ph_r != 2'h3;
		end
	end
endmodule // radio_peer_model

// ==== core/buf2.v ====
// two-entry valid/ready buffer; both outputs and in_ready come from flops
// assumes source and sink on the same clock
`timescale 1ns/1ps
module buf2 #(
	parameter W = 9
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire         in_valid,
	input  wire [W-1:0] in_data,
	output wire         in_ready,
	output wire         out_valid,
	output wire [W-1:0] out_data,
	input  wire         out_ready
);
	reg [W-1:0] main_r;
	reg [W-1:0] skid_r;
	reg         main_v_r;
	reg         skid_v_r;
	wire        push;
	wire        pop;

	assign in_ready  = ~skid_v_r;
	assign out_valid = main_v_r;
	assign out_data  = main_r;
	assign push      = in_valid & ~skid_v_r;
	assign pop       = main_v_r & out_ready;

	// the skid slot catches the word taken in the cycle the sink stalls
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			main_r   <= {W{1'b0}};
			skid_r   <= {W{1'b0}};
			main_v_r <= 1'b0;
			skid_v_r <= 1'b0;
		end
		else if (!main_v_r || pop)
		begin
			if (skid_v_r)
			begin
				main_r   <= skid_r;
				main_v_r <= 1'b1;
				skid_v_r <= 1'b0;
			end
			else
			begin
				main_r   <= in_data;
				main_v_r <= push;
			end
		end
		else if (push)
		begin
			skid_r   <= in_data;
			skid_v_r <= 1'b1;
		end
	end
endmodule // buf2

// ==== core/pin_filter.v ====
// three-flop synchroniser and debounce for the sleep-control pin
// assumes an asynchronous pin; delay given in core clock cycles
`timescale 1ns/1ps
`include "link_ctrl_map.vh"
module pin_filter #(
	parameter DW = 23
) (
	input  wire          clk,
	input  wire          rst_n,
	input  wire          pin_i,
	input  wire [DW-1:0] delay_cyc,
	output reg           rise_r,
	output reg           fall_r
);
	reg          s1_r;
	reg          s2_r;
	reg          s3_r;
	reg          level_r;
	reg [DW-1:0] cnt_r;

	// a new level counts only after it has held for the whole delay
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_r    <= `SLEEP_PIN_RST;
			s2_r    <= `SLEEP_PIN_RST;
			s3_r    <= `SLEEP_PIN_RST;
			level_r <= `SLEEP_PIN_RST;
			cnt_r   <= {DW{1'b0}};
			rise_r  <= 1'b0;
			fall_r  <= 1'b0;
		end
		else
		begin
			s1_r   <= pin_i;
			s2_r   <= s1_r;
			s3_r   <= s2_r;
			rise_r <= 1'b0;
			fall_r <= 1'b0;
			if (s2_r != s3_r || s3_r == level_r)
				cnt_r <= {DW{1'b0}};
			else if (cnt_r >= delay_cyc)
			begin
				level_r <= s3_r;
				rise_r  <= s3_r;
				fall_r  <= ~s3_r;
				cnt_r   <= {DW{1'b0}};
			end
			else
				cnt_r <= cnt_r + 1'b1;
		end
	end
endmodule // pin_filter

// ==== core/radio_link_ctrl.v ====
// link control: addressing, rx filter, led, tdma slots, pin sleep, rssi report
// assumes radio engine and host streams on clk; sleep pin is asynchronous
`timescale 1ns/1ps
`include "link_ctrl_map.vh"
module radio_link_ctrl #(
	parameter SLOT_NB_CYC = `SLOT_NB_US * `CLK_MHZ,
	parameter SLOT_WB_CYC = `SLOT_WB_US * `CLK_MHZ,
	parameter WAKE_CYC    = `WAKE_US * `CLK_MHZ,
	parameter MS_CYC      = `MS_US * `CLK_MHZ,
	parameter LED_CYC     = `LED_PULSE_US * `CLK_MHZ,
	parameter SMP_CYC     = `RSSI_SMP_US * `CLK_MHZ
) (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        addr_mode,
	input  wire [7:0]  dest_addr,
	input  wire [7:0]  local_addr,
	input  wire        sync_mode,
	input  wire        tdma_master,
	input  wire [7:0]  slot_count,
	input  wire [7:0]  slot_index,
	input  wire        tdma_sync,
	input  wire        wide_band,
	input  wire        low_power_en,
	input  wire [6:0]  debounce_ms,
	input  wire [1:0]  rssi_mode,
	input  wire signed [7:0] chan_rssi,
	input  wire        low_batt,
	input  wire        tx_in_valid,
	input  wire [7:0]  tx_in_data,
	input  wire        tx_in_last,
	output wire        tx_in_ready,
	output wire        tx_out_valid,
	output wire [7:0]  tx_out_data,
	output wire        tx_out_last,
	input  wire        tx_out_ready,
	input  wire        rx_in_valid,
	input  wire [7:0]  rx_in_data,
	input  wire        rx_in_last,
	input  wire [7:0]  rx_in_len,
	input  wire [7:0]  rx_in_rssi,
	output wire        rx_in_ready,
	output wire        rx_out_valid,
	output wire [7:0]  rx_out_data,
	output wire        rx_out_last,
	input  wire        rx_out_ready,
	input  wire        sleep_pin_i,
	output reg         sleep_pin_o,
	output reg         sleep_pin_oe,
	output reg         led_r,
	output reg         asleep_r,
	output reg         radio_ready_r,
	output reg  [7:0]  cur_slot_r,
	output reg         slot_mine_r,
	output reg         cycle_start_r,
	output reg         rssi_pwm_r
);
	// ************************************************************
	// states
	// ************************************************************
	localparam TX_IDLE = 2'h0;
	localparam TX_DST  = 2'h1;
	localparam TX_SRC  = 2'h2;
	localparam TX_PAY  = 2'h3;
	localparam RX_IDLE = 3'h0;
	localparam RX_DST  = 3'h1;
	localparam RX_SRC  = 3'h2;
	localparam RX_LEN  = 3'h3;
	localparam RX_RSSI = 3'h4;
	localparam RX_PAY  = 3'h5;
	localparam RX_DROP = 3'h6;

	reg  [1:0]  tx_st_r;
	reg  [1:0]  tx_st_nxt;
	reg  [2:0]  rx_st_r;
	reg  [2:0]  rx_st_nxt;
	wire        addressed = addr_mode;
	wire        tc_v;
	wire [8:0]  tc_d;
	reg         tc_pop;
	reg         td_v;
	reg  [8:0]  td_d;
	wire        td_rdy;
	wire        ra_v;
	wire [24:0] ra_d;
	reg         ra_pop;
	reg         rb_v;
	reg  [8:0]  rb_d;
	wire        rb_rdy;
	wire        tx_done = (tx_st_r == TX_PAY) & tc_v & td_rdy & tc_d[8];
	wire        rx_done = (rx_st_r == RX_PAY) & ra_v & rb_rdy & ra_d[8];
	reg         sleep_pend_r;
	wire        may_start = radio_ready_r & ~sleep_pend_r;
	wire        tx_grant = may_start & (~sync_mode | slot_mine_r);
	wire [7:0]  rssi_cl;

	// ************************************************************
	// buffers on every stream edge
	// ************************************************************
	buf2 #(.W(9)) u_tx_in (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (tx_in_valid),
		.in_data   ({tx_in_last, tx_in_data}),
		.in_ready  (tx_in_ready),
		.out_valid (tc_v),
		.out_data  (tc_d),
		.out_ready (tc_pop)
	);
	buf2 #(.W(9)) u_tx_out (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (td_v),
		.in_data   (td_d),
		.in_ready  (td_rdy),
		.out_valid (tx_out_valid),
		.out_data  ({tx_out_last, tx_out_data}),
		.out_ready (tx_out_ready)
	);
	buf2 #(.W(25)) u_rx_in (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (rx_in_valid),
		.in_data   ({rx_in_rssi, rx_in_len, rx_in_last, rx_in_data}),
		.in_ready  (rx_in_ready),
		.out_valid (ra_v),
		.out_data  (ra_d),
		.out_ready (ra_pop)
	);
	buf2 #(.W(9)) u_rx_out (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (rb_v),
		.in_data   (rb_d),
		.in_ready  (rb_rdy),
		.out_valid (rx_out_valid),
		.out_data  ({rx_out_last, rx_out_data}),
		.out_ready (rx_out_ready)
	);

	// ************************************************************
	// transmit framing
	// ************************************************************
	// in tdma mode a frame only starts inside our slot; once started it runs to its end
	always @*
	begin
		tx_st_nxt = tx_st_r;
		tc_pop    = 1'b0;
		td_v      = 1'b0;
		td_d      = 9'h000;
		case (tx_st_r)
			TX_IDLE:
				if (tc_v && tx_grant)
					tx_st_nxt = addressed ? TX_DST : TX_PAY;
			TX_DST:
			begin
				td_v = 1'b1;
				td_d = {1'b0, dest_addr};
				if (td_rdy)
					tx_st_nxt = TX_SRC;
			end
			TX_SRC:
			begin
				td_v = 1'b1;
				td_d = {1'b0, local_addr};
				if (td_rdy)
					tx_st_nxt = TX_PAY;
			end
			TX_PAY:
			begin
				td_v   = tc_v;
				td_d   = tc_d;
				tc_pop = td_rdy;
				if (tx_done)
					tx_st_nxt = TX_IDLE;
			end
			default:
				tx_st_nxt = TX_IDLE;
		endcase
	end

	// ************************************************************
	// receive filter and serialisation
	// ************************************************************
	assign rssi_cl = ($signed(ra_d[24:17]) < $signed(`RSSI_MIN_DBM)) ? `RSSI_MIN_DBM :
			($signed(ra_d[24:17]) > $signed(`RSSI_MAX_DBM)) ? `RSSI_MAX_DBM :
			ra_d[24:17];

	always @*
	begin
		rx_st_nxt = rx_st_r;
		ra_pop    = 1'b0;
		rb_v      = 1'b0;
		rb_d      = 9'h000;
		case (rx_st_r)
			RX_IDLE:
				if (ra_v && may_start)
					rx_st_nxt = addressed ? RX_DST :
						(rssi_mode == `RSSI_FRAME) ? RX_LEN : RX_PAY;
			RX_DST:
			begin
				ra_pop = 1'b1;
				if (ra_d[8])
					rx_st_nxt = RX_IDLE;
				else if (ra_d[7:0] == local_addr)
					rx_st_nxt = RX_SRC;
				else if (ra_d[7:0] == `BCAST_ADDR)
					rx_st_nxt = RX_SRC;
				else
					rx_st_nxt = RX_DROP;
			end
			RX_SRC:
			begin
				ra_pop = ra_v;
				if (ra_v)
					rx_st_nxt = ra_d[8] ? RX_IDLE :
						(rssi_mode == `RSSI_FRAME) ? RX_LEN : RX_PAY;
			end
			RX_LEN:
			begin
				rb_v = ra_v;
				rb_d = {1'b0, ra_d[16:9]};
				if (ra_v && rb_rdy)
					rx_st_nxt = RX_RSSI;
			end
			RX_RSSI:
			begin
				rb_v = ra_v;
				rb_d = {1'b0, rssi_cl};
				if (ra_v && rb_rdy)
					rx_st_nxt = RX_PAY;
			end
			RX_PAY:
			begin
				rb_v   = ra_v;
				rb_d   = ra_d[8:0];
				ra_pop = rb_rdy;
				if (rx_done)
					rx_st_nxt = RX_IDLE;
			end
			RX_DROP:
			begin
				ra_pop = 1'b1;
				if (ra_v && ra_d[8])
					rx_st_nxt = RX_IDLE;
			end
			default:
				rx_st_nxt = RX_IDLE;
		endcase
	end

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_st_r <= TX_IDLE;
			rx_st_r <= RX_IDLE;
		end
		else
		begin
			tx_st_r <= tx_st_nxt;
			rx_st_r <= rx_st_nxt;
		end
	end

	// ************************************************************
	// status led
	// ************************************************************
	reg [31:0] led_cnt_r;
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			led_cnt_r <= 32'h0;
			led_r     <= 1'b0;
		end
		else
		begin
			if (tx_done || rx_done)
				led_cnt_r <= LED_CYC;
			else if (led_cnt_r != 32'h0)
				led_cnt_r <= led_cnt_r - 1'b1;
			led_r <= low_batt | (led_cnt_r != 32'h0);
		end
	end

	// ************************************************************
	// tdma slot timing
	// ************************************************************
	// slot 0 belongs to the master; slaves realign on the master's sync
	reg  [31:0] slot_tmr_r;
	wire [7:0]  eff_slots = (slot_count < `MIN_SLOTS) ? `MIN_SLOTS : slot_count;
	wire [31:0] slot_len  = wide_band ? SLOT_WB_CYC : SLOT_NB_CYC;
	wire [7:0]  own_slot  = tdma_master ? 8'h00 : slot_index;
	wire        slot_end  = (slot_tmr_r == 32'h0);
	wire [7:0]  slot_next = (cur_slot_r + 8'h01 >= eff_slots) ? 8'h00 : cur_slot_r + 8'h01;

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			slot_tmr_r    <= 32'h0;
			cur_slot_r    <= 8'h00;
			slot_mine_r   <= 1'b0;
			cycle_start_r <= 1'b0;
		end
		else if (!sync_mode)
		begin
			slot_tmr_r    <= 32'h0;
			cur_slot_r    <= 8'h00;
			slot_mine_r   <= 1'b0;
			cycle_start_r <= 1'b0;
		end
		else
		begin
			if ((tdma_sync && !tdma_master) || slot_end)
				slot_tmr_r <= slot_len - 1'b1;
			else
				slot_tmr_r <= slot_tmr_r - 1'b1;
			if (tdma_sync && !tdma_master)
				cur_slot_r <= 8'h00;
			else if (slot_end)
				cur_slot_r <= slot_next;
			cycle_start_r <= slot_end & (slot_next == 8'h00);
			slot_mine_r   <= (cur_slot_r == own_slot);
		end
	end

	// ************************************************************
	// pin-controlled sleep
	// ************************************************************
	wire        pin_rise;
	wire        pin_fall;
	wire [6:0]  deb_ms   = (debounce_ms > `DEB_MAX_MS) ? `DEB_MAX_MS : debounce_ms;
	wire [31:0] deb_prod = deb_ms * MS_CYC;
	wire        lp_act   = low_power_en & ~sync_mode;
	reg  [31:0] wake_cnt_r;

	pin_filter #(.DW(23)) u_pin (
		.clk       (clk),
		.rst_n     (rst_n),
		.pin_i     (sleep_pin_i),
		.delay_cyc (deb_prod[22:0]),
		.rise_r    (pin_rise),
		.fall_r    (pin_fall)
	);

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sleep_pend_r  <= 1'b0;
			asleep_r      <= 1'b0;
			wake_cnt_r    <= 32'h0;
			radio_ready_r <= 1'b0;
			sleep_pin_o   <= 1'b0;
			sleep_pin_oe  <= 1'b0;
		end
		else
		begin
			sleep_pin_o  <= 1'b0;
			sleep_pin_oe <= 1'b0;
			if (!lp_act)
			begin
				sleep_pend_r <= 1'b0;
				asleep_r     <= 1'b0;
			end
			else if (pin_rise)
			begin
				sleep_pend_r <= 1'b0;
				asleep_r     <= 1'b0;
				if (asleep_r)
					wake_cnt_r <= WAKE_CYC;
			end
			else if (pin_fall)
				sleep_pend_r <= 1'b1;
			else if (sleep_pend_r && tx_st_r == TX_IDLE && rx_st_r == RX_IDLE)
			begin
				sleep_pend_r <= 1'b0;
				asleep_r     <= 1'b1;
			end
			if (!(lp_act && pin_rise && asleep_r) && wake_cnt_r != 32'h0)
				wake_cnt_r <= wake_cnt_r - 1'b1;
			// a pending sleep drops ready early, so ready never lags asleep_r by a cycle
			radio_ready_r <= ~asleep_r & ~sleep_pend_r & (wake_cnt_r == 32'h0)
				& ~(lp_act & pin_rise & asleep_r);
		end
	end

	// ************************************************************
	// rssi pwm
	// ************************************************************
	function [9:0] duty_pt;
		input [3:0] i;
		case (i)
			4'h0: duty_pt = 10'h0AA;
			4'h1: duty_pt = 10'h0C6;
			4'h2: duty_pt = 10'h100;
			4'h3: duty_pt = 10'h13F;
			4'h4: duty_pt = 10'h178;
			4'h5: duty_pt = 10'h1BD;
			4'h6: duty_pt = 10'h216;
			4'h7: duty_pt = 10'h250;
			4'h8: duty_pt = 10'h294;
			4'h9: duty_pt = 10'h2BF;
			4'hA: duty_pt = 10'h2FE;
			4'hB: duty_pt = 10'h33E;
			default: duty_pt = 10'h37C;
		endcase
	endfunction

	// linear between 10 dB points; *26/256 stands in for /10, within one permille
	function [9:0] duty_of;
		input signed [7:0] r;
		integer lvl;
		integer seg;
		integer frac;
		integer d;
		begin
			lvl = r;
			if (lvl < -120)
				lvl = -120;
			if (lvl > 0)
				lvl = 0;
			seg  = (lvl + 120) / 10;
			frac = lvl + 120 - seg * 10;
			if (seg >= 12)
				d = duty_pt(4'hC);
			else
				d = duty_pt(seg[3:0]) + ((duty_pt(seg[3:0] + 4'h1) - duty_pt(seg[3:0])) * frac * 26) / 256;
			duty_of = d[9:0];
		end
	endfunction

	reg [31:0] smp_cnt_r;
	reg [9:0]  duty_r;
	reg [9:0]  pwm_cnt_r;
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			smp_cnt_r  <= 32'h0;
			duty_r     <= 10'h000;
			pwm_cnt_r  <= 10'h000;
			rssi_pwm_r <= 1'b0;
		end
		else if (rssi_mode != `RSSI_PWM)
		begin
			smp_cnt_r  <= 32'h0;
			pwm_cnt_r  <= 10'h000;
			rssi_pwm_r <= 1'b0;
		end
		else
		begin
			if (smp_cnt_r == 32'h0)
			begin
				smp_cnt_r <= SMP_CYC - 1;
				duty_r    <= duty_of(chan_rssi);
			end
			else
				smp_cnt_r <= smp_cnt_r - 1'b1;
			pwm_cnt_r  <= (pwm_cnt_r == `PWM_PERIOD - 10'h001) ? 10'h000 : pwm_cnt_r + 10'h001;
			rssi_pwm_r <= (pwm_cnt_r < duty_r);
		end
	end
endmodule // radio_link_ctrl

// ==== pkg/link_ctrl_map.vh ====
// constants for the radio modem link control block
// assumes a 50 MHz core clock; included by bare name from the core files
//
// Notes on behaviour
// - transparent mode sends frames with no address bytes; host embeds any address
// - addressed mode puts configured destination in every frame; 255 means broadcast
// - addressed receive keeps only frames whose destination equals local address or broadcast 255
// - led pulses after each frame sent or received; steady while battery is low
// - tdma slot lasts 75.5 ms narrow band, 17.5 ms wide band
// - tdma cycle is slot time times slot count
// - slot count is forced to at least 11 to keep 10% duty
// - low power is off after reset; on only when enable is set to 1
// - with low power off the sleep pin is never driven and ignored
// - sleep pin falling edge sleeps once current tx or rx ends; no radio asleep
// - sleep pin rising edge wakes; radio usable about 7 ms later
// - sleep pin debounce delay configurable from 0 to 100 ms
// - pin sleep control works only in asynchronous access mode
// - rssi mode 0 gives no signal strength output
// - rssi mode 1 frames out as length, rssi, then payload of up to 60 bytes
// - reported rssi byte is dBm, clamped to -127 .. -8
// - rssi mode 2 samples channel rssi every few hundred us, drives pwm pin
// - pwm duty rises with level: 17% at -120 dBm, 89.2% at 0 dBm
// - addressed mode only when addressing setting is 1, else transparent
`ifndef LINK_CTRL_MAP_VH
`define LINK_CTRL_MAP_VH

// ************************************************************
// timing
// ************************************************************
`define CLK_MHZ        50
`define SLOT_NB_US     75500
`define SLOT_WB_US     17500
`define WAKE_US        7000
`define MS_US          1000
`define LED_PULSE_US   50000
`define RSSI_SMP_US    300
`define DEB_MAX_MS     7'h64

// ************************************************************
// link values
// ************************************************************
`define BCAST_ADDR     8'hFF
`define MIN_SLOTS      8'h0B
`define MAX_PAYLOAD    8'h3C
`define RSSI_MIN_DBM   8'h81
`define RSSI_MAX_DBM   8'hF8
`define RSSI_OFF       2'h0
`define RSSI_FRAME     2'h1
`define RSSI_PWM       2'h2
`define PWM_PERIOD     10'h3E8
`define SLEEP_PIN_RST  1'h1

`endif
